// file: hdl/power_mode_pkg.sv
// Constants and types for the power mode supervisor
package power_mode_pkg;
  // ==========================================================================
  // Device power modes
  typedef enum logic [2:0] {
    MODE_GO = 3'h0,
    MODE_READY = 3'h1,
    MODE_IDLE = 3'h2,
    MODE_STANDBY = 3'h3,
    MODE_STOP = 3'h4
  } pwr_mode_t;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_RESET = 3'h0,
    SEQ_CTRL_UP = 3'h1,
    SEQ_CORE_UP = 3'h2,
    SEQ_ACTIVE = 3'h3,
    SEQ_LOWPWR = 3'h4
  } seq_state_t;

  // ==========================================================================
  // Wake source bit positions
  localparam int WAKE_W = 8;
  localparam int WK_TIMER = 0;
  localparam int WK_CMP = 1;
  localparam int WK_CAL = 2;
  localparam int WK_PIN = 3;
  localparam int WK_SERIAL = 4;
  localparam int WK_TWOWIRE = 5;
  localparam int WK_BROWNOUT = 6;
  localparam int WK_OTHER = 7;
  localparam logic [WAKE_W-1:0] WAKE_STOP_MASK = 8'h4f;
  localparam logic [WAKE_W-1:0] WAKE_STANDBY_MASK = 8'h7f;
  localparam logic [WAKE_W-1:0] WAKE_ALL_MASK = 8'hff;

  // ==========================================================================
  // Sequencing times
  localparam int CLK_MHZ = 40;
  localparam int DOMAIN_SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (DOMAIN_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYC);
  localparam int NUM_UNITS = 8;
  localparam logic [2:0] MODE_RESET = 3'h0;
endpackage : power_mode_pkg

// file: hdl/power_mode_supervisor.sv
// Power mode supervisor: modes, domain enables, wake filter, supply supervisors
// ==========================================================================
// Summary of operation
// - GO: core runs, every wake source accepted
// - READY: core clock gated, peripherals stay alive
// - IDLE: core powered off, outside peripherals wake
// - Sleep gates core clock; off removes core power
// - STANDBY: subsystem, performance shared off; all wakes but other
// - STOP: both regions off; timer/cmp/cal/pin wake
// - Subsystem off also powers its four ports off
// - Per-unit clock enable, one common divider, in every mode
// - Battery reset clears all state at ramp
// - Brownout detect interrupts core, security, DMA
// - Brownout detect wakes from STANDBY and STOP
// - Brownout reset clears whole device immediately
// - Control domain powers up first after always-on
// - After brownout reset, full cold power-on
`timescale 1ns/1ps
`default_nettype none
module power_mode_supervisor (
  input wire logic clk_i, // 40 MHz supervisor clock
  input wire logic sys_rst_i, // Battery-rail power-on reset, active high
  input wire logic brownout_reset_i, // Supply under reset threshold, async pin
  input wire logic brownout_detect_i, // Supply under detect threshold, async pin
  input wire logic lowpower_req_i, // Software request to enter target mode
  input wire power_mode_pkg::pwr_mode_t target_mode_i, // Software target mode
  input wire logic [power_mode_pkg::WAKE_W-1:0] wake_i, // Wake pins, async
  input wire logic [power_mode_pkg::NUM_UNITS-1:0] unit_clk_en_i, // Per-unit gate
  input wire logic [3:0] unit_div_i, // Common divide ratio minus one
  output logic [2:0] mode_o, // Current device power mode
  output logic core_clk_en_o, // Realtime core clock enable
  output logic core_pwr_en_o, // Efficient core subsystem power
  output logic subsys_ports_pwr_o, // Camera, audio, pdm, spi ports power
  output logic ctrl_domain_pwr_o, // Efficiency control domain power
  output logic perf_shared_pwr_o, // Performance region shared power
  output logic eff_shared_pwr_o, // Efficiency region shared power
  output logic [power_mode_pkg::NUM_UNITS-1:0] unit_clk_o, // Per-unit clock pulses
  output logic core_bod_irq_o, // Brownout interrupt to realtime core
  output logic sec_bod_irq_o, // Brownout interrupt to security processor
  output logic bod_dma_req_o, // Brownout DMA request pulse
  output logic device_rst_o // Device-wide reset output
);
  import power_mode_pkg::*;

  // ==========================================================================
  // Input synchronisers (three stages, change taken when last two agree)
  logic [2:0] bor_sync_r, bod_sync_r;
  logic [WAKE_W-1:0] wk_s1_r, wk_s2_r, wk_s3_r, wake_r;
  logic bor_r, bod_r, bod_prev_r;
  logic bor_async_rst;

  // Battery reset async; brownout pin asserts async, release via the filter
  assign bor_async_rst = sys_rst_i | brownout_reset_i;

  // Filter held at reset level so a short brownout cannot release early
  always_ff @(posedge clk_i or posedge bor_async_rst) begin
    if (bor_async_rst) begin
      bor_sync_r <= 3'h7;
      bod_sync_r <= 3'h0;
      bor_r <= 1'b1;
      bod_r <= 1'b0;
    end else begin
      bor_sync_r <= {bor_sync_r[1:0], brownout_reset_i};
      bod_sync_r <= {bod_sync_r[1:0], brownout_detect_i};
      if (bor_sync_r[1] == bor_sync_r[2]) bor_r <= bor_sync_r[2];
      if (bod_sync_r[1] == bod_sync_r[2]) bod_r <= bod_sync_r[2];
    end
  end

  // Wake pins, each bit filtered the same way
  always_ff @(posedge clk_i or posedge bor_async_rst) begin
    if (bor_async_rst) begin
      wk_s1_r <= '0;
      wk_s2_r <= '0;
      wk_s3_r <= '0;
      wake_r <= '0;
    end else begin
      wk_s1_r <= wake_i;
      wk_s2_r <= wk_s1_r;
      wk_s3_r <= wk_s2_r;
      for (int i = 0; i < WAKE_W; i++) begin
        if (wk_s2_r[i] == wk_s3_r[i]) wake_r[i] <= wk_s3_r[i];
      end
    end
  end

  // ==========================================================================
  // Device reset output: set at once, released only after the filter clears
  // Reset output held while the brownout reset supervisor is active; brownout detect does not hold it
  always_ff @(posedge clk_i or posedge bor_async_rst) begin
    if (bor_async_rst) begin
      device_rst_o <= 1'b1;
    end else begin
      device_rst_o <= bor_r; // Released after filtered brownout clears
    end
  end

  // ==========================================================================
  // Power sequencer
  seq_state_t state_r;
  pwr_mode_t mode_r;
  logic [7:0] settle_r;
  logic [WAKE_W-1:0] wake_mask;
  logic wake_hit;

  // Allowed wake sources per mode; brownout detect counts as a wake
  always_comb begin
    unique case (mode_r)
      MODE_STOP: wake_mask = WAKE_STOP_MASK;
      MODE_STANDBY: wake_mask = WAKE_STANDBY_MASK;
      default: wake_mask = WAKE_ALL_MASK;
    endcase
  end
  assign wake_hit = |({wake_r[WAKE_W-1], bod_r, wake_r[WAKE_W-3:0]} & wake_mask);

  // Cold start after any reset: control domain, then core, then GO
  always_ff @(posedge clk_i or posedge bor_async_rst) begin
    if (bor_async_rst) begin
      state_r <= SEQ_RESET;
      mode_r <= MODE_GO;
      settle_r <= 8'h0;
    end else begin
      unique case (state_r)
        SEQ_RESET: begin
          if (!bor_r) begin
            state_r <= SEQ_CTRL_UP;
            settle_r <= SETTLE_CNT;
          end
        end
        SEQ_CTRL_UP, SEQ_CORE_UP: begin
          if (settle_r > 8'h1) begin
            settle_r <= settle_r - 8'h1;
          end else begin
            state_r <= (state_r == SEQ_CTRL_UP) ? SEQ_CORE_UP : SEQ_ACTIVE;
            settle_r <= SETTLE_CNT;
            mode_r <= MODE_GO;
          end
        end
        SEQ_ACTIVE: begin
          if (lowpower_req_i && target_mode_i != MODE_GO) begin
            mode_r <= target_mode_i;
            state_r <= SEQ_LOWPWR;
          end
        end
        SEQ_LOWPWR: begin
          if (wake_hit) begin
            // Domains shut in deep modes need settle time before GO
            if (mode_r == MODE_STOP) begin
              state_r <= SEQ_CTRL_UP;
              settle_r <= SETTLE_CNT;
            end else if (mode_r == MODE_READY) begin
              state_r <= SEQ_ACTIVE;
              mode_r <= MODE_GO;
            end else begin
              state_r <= SEQ_CORE_UP;
              settle_r <= SETTLE_CNT;
            end
          end
        end
        default: state_r <= SEQ_RESET;
      endcase
    end
  end

  // ==========================================================================
  // Domain enables from state and mode
  always_ff @(posedge clk_i or posedge bor_async_rst) begin
    if (bor_async_rst) begin
      mode_o <= MODE_RESET;
      ctrl_domain_pwr_o <= 1'b0;
      core_pwr_en_o <= 1'b0;
      subsys_ports_pwr_o <= 1'b0;
      core_clk_en_o <= 1'b0;
      perf_shared_pwr_o <= 1'b0;
      eff_shared_pwr_o <= 1'b0;
    end else begin
      mode_o <= mode_r;
      ctrl_domain_pwr_o <= (state_r != SEQ_RESET) &&
                           !(state_r == SEQ_LOWPWR && mode_r == MODE_STOP);
      core_pwr_en_o <= (state_r == SEQ_ACTIVE) ||
                       (state_r == SEQ_LOWPWR && mode_r == MODE_READY);
      subsys_ports_pwr_o <= (state_r == SEQ_ACTIVE) ||
                            (state_r == SEQ_LOWPWR && mode_r == MODE_READY);
      core_clk_en_o <= (state_r == SEQ_ACTIVE);
      perf_shared_pwr_o <= (state_r == SEQ_ACTIVE) ||
                           (state_r == SEQ_LOWPWR &&
                            (mode_r == MODE_READY || mode_r == MODE_IDLE));
      eff_shared_pwr_o <= (state_r == SEQ_ACTIVE) ||
                          (state_r == SEQ_LOWPWR && mode_r != MODE_STOP);
    end
  end

  // ==========================================================================
  // Per-unit clock enables: one divider, gated per unit; works in any mode
  logic [3:0] div_cnt_r;
  always_ff @(posedge clk_i or posedge bor_async_rst) begin
    if (bor_async_rst) begin
      div_cnt_r <= 4'h0;
      unit_clk_o <= '0;
    end else begin
      div_cnt_r <= (div_cnt_r >= unit_div_i) ? 4'h0 : div_cnt_r + 4'h1;
      unit_clk_o <= (div_cnt_r == 4'h0) ? unit_clk_en_i : '0;
    end
  end

  // ==========================================================================
  // Brownout detect: level interrupts, one-cycle DMA request on entry
  always_ff @(posedge clk_i or posedge bor_async_rst) begin
    if (bor_async_rst) begin
      bod_prev_r <= 1'b0;
      core_bod_irq_o <= 1'b0;
      sec_bod_irq_o <= 1'b0;
      bod_dma_req_o <= 1'b0;
    end else begin
      bod_prev_r <= bod_r;
      core_bod_irq_o <= bod_r;
      sec_bod_irq_o <= bod_r;
      bod_dma_req_o <= bod_r & ~bod_prev_r;
    end
  end
endmodule : power_mode_supervisor
`default_nettype wire

// file: bench/power_mode_supervisor_properties.sv
// Port-level checks for the power mode supervisor
`timescale 1ns/1ps
`default_nettype none
module power_mode_supervisor_properties (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Battery reset
  input wire logic brownout_reset_i, // Brownout reset pin
  input wire logic lowpower_req_i, // Mode request
  input wire power_mode_pkg::pwr_mode_t target_mode_i, // Requested mode
  input wire logic [2:0] mode_o, // Current mode
  input wire logic core_clk_en_o, // Core clock
  input wire logic core_pwr_en_o, // Core power
  input wire logic subsys_ports_pwr_o, // Subsystem ports power
  input wire logic ctrl_domain_pwr_o, // Control domain power
  input wire logic perf_shared_pwr_o, // Performance shared power
  input wire logic eff_shared_pwr_o, // Efficiency shared power
  input wire logic device_rst_o, // Device reset
  input wire logic [power_mode_pkg::NUM_UNITS-1:0] unit_clk_en_i, // Unit gates
  input wire logic [power_mode_pkg::NUM_UNITS-1:0] unit_clk_o, // Unit pulses
  input wire logic core_bod_irq_o, // Core brownout interrupt
  input wire logic sec_bod_irq_o, // Security brownout interrupt
  input wire logic bod_dma_req_o // Brownout DMA request
);
  import power_mode_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================================
  // Domain enables per mode
  ports_track_core_a: assert property (subsys_ports_pwr_o == core_pwr_en_o)
    else $error("subsystem ports power differs from core power");
  clk_needs_pwr_a: assert property (core_clk_en_o |-> core_pwr_en_o)
    else $error("core clock on without core power");
  ready_sleep_a: assert property (mode_o == MODE_READY |->
    core_pwr_en_o && !core_clk_en_o)
    else $error("ready mode core not in sleep");
  idle_core_off_a: assert property (mode_o == MODE_IDLE |-> !core_pwr_en_o)
    else $error("idle mode core still powered");
  standby_down_a: assert property (mode_o == MODE_STANDBY |->
    !core_pwr_en_o && !perf_shared_pwr_o)
    else $error("standby mode domains still powered");
  stop_down_a: assert property (mode_o == MODE_STOP |->
    !perf_shared_pwr_o && !eff_shared_pwr_o)
    else $error("stop mode shared domains still powered");
  // ==========================================================================
  // Sequencing and resets; the control domain must lead core power by 8 cycles
  ctrl_leads_core_a: assert property ($rose(ctrl_domain_pwr_o) |->
    !core_pwr_en_o [*8])
    else $error("core powered too soon after control domain");
  bor_resets_a: assert property (brownout_reset_i |->
    device_rst_o && !ctrl_domain_pwr_o)
    else $error("brownout reset not applied");
  req_answer_a: assert property (lowpower_req_i && core_clk_en_o && mode_o == MODE_GO
    && target_mode_i != MODE_GO |-> ##2 mode_o == $past(target_mode_i, 2))
    else $error("requested mode not entered in two cycles");
  // ==========================================================================
  // Brownout detect outputs and per-unit clock gating
  irq_pair_a: assert property (core_bod_irq_o == sec_bod_irq_o)
    else $error("brownout interrupts differ");
  dma_on_rise_a: assert property (bod_dma_req_o == $rose(core_bod_irq_o))
    else $error("dma request not a single pulse on brownout entry");
  unit_gate_a: assert property ((unit_clk_o & ~$past(unit_clk_en_i)) == '0)
    else $error("clock pulse on a gated unit");
endmodule : power_mode_supervisor_properties
`default_nettype wire

// file: bench/power_mode_supervisor_tb.sv
// Self-checking bench for the power mode supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((e) !== (g)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module power_mode_supervisor_tb;
  import power_mode_pkg::*;
  logic clk_i = 0, sys_rst_i = 0, bor_i = 0, bod_i = 0, req_i = 0;
  pwr_mode_t tgt = MODE_GO;
  logic [7:0] wk = 0, uen = 0, uclk;
  logic [3:0] udiv = 0;
  logic [2:0] mode;
  logic cclk, cpwr, ports, ctrl, perf, eff, cirq, sirq, dma, drst;
  int error_cnt = 0, n_checks = 0, dma_cnt = 0, cnt[8], k, b, lim, c;
  int modes[$] = '{1, 2, 3, 4, 4, 3};
  initial forever #12.5 clk_i = ~clk_i;
  // Count DMA pulses; one per detect rise
  always @(negedge clk_i) dma_cnt += dma;
  power_mode_supervisor u_power_mode_supervisor (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .brownout_reset_i(bor_i), .brownout_detect_i(bod_i), .lowpower_req_i(req_i),
    .target_mode_i(tgt), .wake_i(wk), .unit_clk_en_i(uen), .unit_div_i(udiv), .mode_o(mode),
    .core_clk_en_o(cclk), .core_pwr_en_o(cpwr), .subsys_ports_pwr_o(ports),
    .ctrl_domain_pwr_o(ctrl), .perf_shared_pwr_o(perf), .eff_shared_pwr_o(eff),
    .unit_clk_o(uclk), .core_bod_irq_o(cirq), .sec_bod_irq_o(sirq), .bod_dma_req_o(dma),
    .device_rst_o(drst));
  // Model: {core clock, core power, perf shared, eff shared} per mode
  function automatic logic [3:0] exp_pwr(int m);
    logic [3:0] t[5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0};
    return t[m];
  endfunction : exp_pwr
  // Bounded wait for GO; counts cycles with control domain up and core down
  task automatic wait_go();
    c = 0;
    for (k = 0; k < 400 && cclk !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
      if (ctrl === 1'b1 && cpwr !== 1'b1) c++;
    end
    `CHK("woke", 1'b1, cclk)
  endtask : wait_go
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Watchdog sized well beyond the expected several hundred cycles
  initial begin
    #500000;
    error_cnt++;
    report_and_stop();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    k = $urandom(32'h06da);
    #1 sys_rst_i = 1; // Raised after time zero so the reset edge is seen
    #9 `CHK("por", 4'h8, {drst, cpwr, ctrl, cclk})
    repeat (8) @(negedge clk_i);
    sys_rst_i = 0;
    wait_go();
    `CHK("ctrl_lead", 2 * SETTLE_CYC, c)
    `CHK("rst_rel", 1'b0, drst)
    `CHK("go_pwr", exp_pwr(0), {cclk, cpwr, perf, eff})
    foreach (modes[i]) begin
      @(negedge clk_i);
      tgt = pwr_mode_t'(modes[i]);
      req_i = 1;
      @(negedge clk_i);
      req_i = 0;
      repeat (2) @(negedge clk_i);
      `CHK("mode", 3'(modes[i]), mode)
      `CHK("pwr", exp_pwr(modes[i]), {cclk, cpwr, perf, eff})
      `CHK("ports", modes[i] == 1, ports)
      if (modes[i] >= 3) begin
        b = (modes[i] == 3) ? 7 : 4 + $urandom % 3;
        if (b == 6) b = 7;
        wk[b] = 1;
        repeat (20) @(negedge clk_i);
        `CHK("masked", 3'(modes[i]), mode)
      end
      lim = modes[i] == 4 ? 4 : modes[i] == 3 ? 6 : 8;
      b = $urandom % lim;
      if (b == 6) b = 7;
      // Last two wakes come from brownout detect, the rest from one pin
      bod_i = (i > 3);
      wk = (i > 3) ? 8'h0 : 8'h1 << b;
      wait_go();
      `CHK("irq", {bod_i, bod_i}, {cirq, sirq})
      `CHK("go_mode", MODE_GO, mode)
      `CHK("dma", i > 3 ? i - 3 : 0, dma_cnt)
      @(negedge clk_i);
      wk = 0;
      bod_i = 0;
      repeat (8) @(negedge clk_i);
    end
    // Per-unit clock gating and division in GO
    repeat (2) begin
      udiv = 4'($urandom % 4);
      uen = 8'($urandom);
      repeat (5) @(negedge clk_i);
      cnt = '{default: 0};
      repeat (8 * (udiv + 1)) begin
        @(negedge clk_i);
        foreach (cnt[j]) cnt[j] += uclk[j];
      end
      foreach (cnt[j]) `CHK("unit_clk", uen[j] ? 8 : 0, cnt[j])
    end
    // Brownout reset mid-run, then a full cold sequence
    bor_i = 1;
    #1 `CHK("bor", 4'h8, {drst, cpwr, ctrl, perf})
    repeat (3) @(negedge clk_i);
    bor_i = 0;
    wait_go();
    `CHK("cold_seq", 2 * SETTLE_CYC, c)
    `CHK("cold_rel", 1'b0, drst)
    report_and_stop();
  end
endmodule : power_mode_supervisor_tb
bind power_mode_supervisor power_mode_supervisor_properties u_props (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .brownout_reset_i(brownout_reset_i), .lowpower_req_i(lowpower_req_i),
  .target_mode_i(target_mode_i), .mode_o(mode_o), .core_clk_en_o(core_clk_en_o),
  .core_pwr_en_o(core_pwr_en_o), .subsys_ports_pwr_o(subsys_ports_pwr_o),
  .ctrl_domain_pwr_o(ctrl_domain_pwr_o), .perf_shared_pwr_o(perf_shared_pwr_o),
  .eff_shared_pwr_o(eff_shared_pwr_o), .device_rst_o(device_rst_o),
  .unit_clk_en_i(unit_clk_en_i), .unit_clk_o(unit_clk_o), .core_bod_irq_o(core_bod_irq_o),
  .sec_bod_irq_o(sec_bod_irq_o), .bod_dma_req_o(bod_dma_req_o));
`default_nettype wire
